// *** svrm_regs.svh ***
// constants of the supply voltage reset monitor
`ifndef SVRM_REGS_SVH
`define SVRM_REGS_SVH
`define SVRM_CLK_HZ          20000000
// processing times in nanoseconds
`define SVRM_T_EXT1_LVD_NS   832000
`define SVRM_T_EXT1_OFF_NS   519000
`define SVRM_T_EXT2_LVD_NS   675000
`define SVRM_T_EXT2_OFF_NS   362000
`define SVRM_T_LVD_RST_NS    70100
`define SVRM_T_LVD_TYP_NS    51100
// cycle counts: longest times round down
`define SVRM_CY_EXT1_LVD     ((`SVRM_T_EXT1_LVD_NS * 20) / 1000)
`define SVRM_CY_EXT1_OFF     ((`SVRM_T_EXT1_OFF_NS * 20) / 1000)
`define SVRM_CY_EXT2_LVD     ((`SVRM_T_EXT2_LVD_NS * 20) / 1000)
`define SVRM_CY_EXT2_OFF     ((`SVRM_T_EXT2_OFF_NS * 20) / 1000)
`define SVRM_CY_LVD_RST      ((`SVRM_T_LVD_RST_NS * 20) / 1000)
`define SVRM_CY_LVD_TYP      ((`SVRM_T_LVD_TYP_NS * 20) / 1000)
// field positions
`define SVRM_CTRL_FLAG_BIT   0
`define SVRM_RSRC_LVD_BIT    0
`define SVRM_LEVEL_BITS      4
// reset values
`define SVRM_LVL_HI          1'b0
`define SVRM_LVL_LO          1'b1
`define SVRM_ACT_IRQ         1'b0
`define SVRM_ACT_RST         1'b1
`endif

// *** svrm_pkg.sv ***
// types of the supply voltage reset monitor
package svrm_pkg;
    typedef enum logic [1:0] {
        SVRM_MODE_OFF   = 2'b00,
        SVRM_MODE_INT   = 2'b01,
        SVRM_MODE_COMB  = 2'b10,
        SVRM_MODE_RST   = 2'b11
    } svrm_mode_t;
    typedef enum logic [1:0] {
        SVRM_ST_POR     = 2'b00,
        SVRM_ST_HOLD    = 2'b01,
        SVRM_ST_PROC    = 2'b10,
        SVRM_ST_RUN     = 2'b11
    } svrm_state_t;
    typedef struct packed {
        logic [1:0]  s1_lo;
        logic [1:0]  s2_lo;
        logic [1:0]  s1_hi;
        logic [1:0]  s2_hi;
        svrm_state_t st;
        logic [15:0] cnt;
        logic        first_done;
        logic        lvd_cause;
        logic        int_released;
        logic        prev_below;
        logic        lvl_sel;
        logic        act_sel;
        logic        irq;
        logic        rst_n_out;
        logic        below_flag;
        logic        lvd_flag;
    } svrm_state_s_t;
endpackage : svrm_pkg

// *** svrm_monitor.sv ***
// supply voltage reset monitor control logic
// Summary of operation
// - processing interval covers oscillator settling time
// - first external release: 0.832/0.519 ms max
// - second external release: 0.675/0.362 ms max
// - combined mode: irq sets level, action bits
// - detector reset processing at most 0.0701 ms
// - reset mode recovery processing 0.0701 ms max
// - interrupt mode startup equals reset mode
// - mode field: 10 combined, 11 reset, 01 interrupt
// - combined: irq below upper, release at upper
// - combined: reset below lower threshold
// - reset mode: single threshold sets and releases
// - interrupt mode: hold reset until first above
// - interrupt mode: irq on every crossing
// - live below flag at control bit 0
// - detector reset sets source flag bit 0
// - power-on reset clears all source flags
// - level bit 0 upper, action bit 1 reset
`timescale 1ns/1ps
`include "svrm_regs.svh"
module svrm_monitor
    import svrm_pkg::*;
#(
    parameter int unsigned CY_EXT1_LVD = `SVRM_CY_EXT1_LVD,
    parameter int unsigned CY_EXT1_OFF = `SVRM_CY_EXT1_OFF,
    parameter int unsigned CY_EXT2_LVD = `SVRM_CY_EXT2_LVD,
    parameter int unsigned CY_EXT2_OFF = `SVRM_CY_EXT2_OFF,
    parameter int unsigned CY_LVD_RST  = `SVRM_CY_LVD_RST
) (
    input  wire logic                        CLK_SYS,
    input  wire logic                        RST_N,
    input  wire logic                        EXT_RESET_N,
    input  wire logic                        DETECTOR_MODE_SEL_HI,
    input  wire logic                        DETECTOR_MODE_SEL_LO,
    input  wire logic [`SVRM_LEVEL_BITS-1:0] LEVEL_CODE,
    input  wire logic                        CMP_BELOW_UPPER,
    input  wire logic                        CMP_BELOW_LOWER,
    input  wire logic                        FLAG_READ,
    output logic [`SVRM_LEVEL_BITS-1:0]      THRESHOLD_CODE,
    output logic                             INTERNAL_RESET_N,
    output logic                             LOW_SUPPLY_IRQ,
    output logic                             SUPPLY_BELOW_FLAG,
    output logic                             LOW_SUPPLY_RESET_FLAG,
    output logic                             THRESHOLD_LEVEL_SELECT,
    output logic                             DETECTOR_ACTION_SELECT
);
    svrm_state_s_t r;
    svrm_state_s_t next_r;
    svrm_mode_t    mode;
    logic          below_hi;
    logic          below_lo;
    logic          below_sel;
    logic          ext_rst;
    logic          lvd_on;
    logic [1:0]    s1_ext;
    logic [1:0]    s2_ext;
    logic [3:0]    lvl_q;

    assign mode     = svrm_mode_t'({DETECTOR_MODE_SEL_HI, DETECTOR_MODE_SEL_LO});
    assign lvd_on   = (mode != SVRM_MODE_OFF) && !(mode == SVRM_MODE_INT && 1'b0);
    assign below_hi = r.s2_hi[0];
    assign below_lo = r.s2_lo[0];
    assign ext_rst  = !s2_ext[0];
    // level bit picks lower comparator, upper otherwise
    assign below_sel = (r.lvl_sel == `SVRM_LVL_LO) ? below_lo : below_hi;

    // external reset pin synchroniser and level code register, outside the struct as they are no control state
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            s1_ext <= 2'b00;
            s2_ext <= 2'b00;
            lvl_q  <= 4'h0;
        end else begin
            s1_ext <= {1'b0, EXT_RESET_N};
            s2_ext <= s1_ext;
            lvl_q  <= LEVEL_CODE;
        end
    end

    always_comb begin
        next_r = r;
        next_r.s1_hi = {1'b0, CMP_BELOW_UPPER};
        next_r.s2_hi = r.s1_hi;
        next_r.s1_lo = {1'b0, CMP_BELOW_LOWER};
        next_r.s2_lo = r.s1_lo;
        next_r.irq = 1'b0;
        next_r.prev_below = below_sel;
        next_r.below_flag = lvd_on && below_sel;
        if (FLAG_READ) begin
            next_r.lvd_flag = 1'b0;
        end
        case (r.st)
            SVRM_ST_POR: begin
                // power-on: flags cleared, defaults from the mode field
                next_r.lvd_flag = 1'b0;
                next_r.lvl_sel  = (mode == SVRM_MODE_COMB) ? `SVRM_LVL_HI : `SVRM_LVL_LO;
                next_r.act_sel  = (mode == SVRM_MODE_RST) ? `SVRM_ACT_RST : `SVRM_ACT_IRQ;
                next_r.st       = SVRM_ST_HOLD;
            end
            SVRM_ST_HOLD: begin
                next_r.rst_n_out = 1'b0;
                next_r.cnt       = 16'h0000;
                if (ext_rst) begin
                    next_r.lvd_cause = 1'b0;
                end else if (mode == SVRM_MODE_OFF || !below_sel) begin
                    // combined: release only at upper level; int: first above
                    if (mode != SVRM_MODE_COMB || !below_hi) begin
                        next_r.st = SVRM_ST_PROC;
                    end
                end
            end
            SVRM_ST_PROC: begin
                // covers high-speed oscillator settling before release
                next_r.cnt = r.cnt + 16'h0001;
                if (ext_rst || (mode != SVRM_MODE_OFF && below_sel)) begin
                    next_r.st = SVRM_ST_HOLD;
                end else if (r.lvd_cause ? (32'(r.cnt) + 32'd1 >= CY_LVD_RST)
                        : !r.first_done ? (32'(r.cnt) + 32'd1 >=
                              (lvd_on ? CY_EXT1_LVD : CY_EXT1_OFF))
                        : (32'(r.cnt) + 32'd1 >=
                              (lvd_on ? CY_EXT2_LVD : CY_EXT2_OFF))) begin
                    next_r.st           = SVRM_ST_RUN;
                    next_r.rst_n_out    = 1'b1;
                    next_r.first_done   = 1'b1;
                    next_r.int_released = 1'b1;
                    next_r.lvd_cause    = 1'b0;
                end
            end
            SVRM_ST_RUN: begin
                if (ext_rst) begin
                    next_r.st        = SVRM_ST_HOLD;
                    next_r.rst_n_out = 1'b0;
                    next_r.lvd_flag  = 1'b0;
                    next_r.lvl_sel   = (mode == SVRM_MODE_COMB) ? `SVRM_LVL_HI : `SVRM_LVL_LO;
                    next_r.act_sel   = (mode == SVRM_MODE_RST) ? `SVRM_ACT_RST : `SVRM_ACT_IRQ;
                end else begin
                    case (mode)
                        SVRM_MODE_COMB: begin
                            if (below_hi && r.lvl_sel == `SVRM_LVL_HI) begin
                                next_r.irq     = 1'b1;
                                next_r.lvl_sel = `SVRM_LVL_LO;
                                next_r.act_sel = `SVRM_ACT_RST;
                            end
                            if (below_lo) begin
                                next_r.st        = SVRM_ST_HOLD;
                                next_r.rst_n_out = 1'b0;
                                next_r.lvd_cause = 1'b1;
                                next_r.lvd_flag  = 1'b1;
                            end
                        end
                        SVRM_MODE_RST: begin
                            if (below_sel) begin
                                next_r.st        = SVRM_ST_HOLD;
                                next_r.rst_n_out = 1'b0;
                                next_r.lvd_cause = 1'b1;
                                next_r.lvd_flag  = 1'b1;
                            end
                        end
                        SVRM_MODE_INT: begin
                            if (r.int_released && below_sel != r.prev_below) begin
                                next_r.irq = 1'b1;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
            default: begin
                next_r.st = SVRM_ST_POR;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            THRESHOLD_CODE <= 4'h0;
        end else begin
            THRESHOLD_CODE <= lvl_q;
        end
    end

    assign INTERNAL_RESET_N       = r.rst_n_out;
    assign LOW_SUPPLY_IRQ         = r.irq;
    assign SUPPLY_BELOW_FLAG      = r.below_flag;
    assign LOW_SUPPLY_RESET_FLAG  = r.lvd_flag;
    assign THRESHOLD_LEVEL_SELECT = r.lvl_sel;
    assign DETECTOR_ACTION_SELECT = r.act_sel;
endmodule : svrm_monitor

// *** svrm_props.sv ***
// assertions of the supply voltage reset monitor
`timescale 1ns/1ps
module svrm_props #(parameter int CY_LVD_RST = 4) (
    input wire logic       CLK_SYS,
    input wire logic       RST_N,
    input wire logic       EXT_RESET_N,
    input wire logic       DETECTOR_MODE_SEL_HI,
    input wire logic       DETECTOR_MODE_SEL_LO,
    input wire logic [3:0] LEVEL_CODE,
    input wire logic       CMP_BELOW_LOWER,
    input wire logic [3:0] THRESHOLD_CODE,
    input wire logic       INTERNAL_RESET_N,
    input wire logic       LOW_SUPPLY_IRQ,
    input wire logic       SUPPLY_BELOW_FLAG,
    input wire logic       THRESHOLD_LEVEL_SELECT,
    input wire logic       DETECTOR_ACTION_SELECT
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    a_irq_pulse: assert property (LOW_SUPPLY_IRQ |=> !LOW_SUPPLY_IRQ)
        else $error("irq wider than one cycle");
    a_ext_forces_rst: assert property (!EXT_RESET_N [*4] |-> !INTERNAL_RESET_N)
        else $error("reset released under external reset");
    a_release_min: assert property ($rose(INTERNAL_RESET_N) |-> $past(!INTERNAL_RESET_N, CY_LVD_RST))
        else $error("reset released too early");
    a_off_no_flag: assert property (!DETECTOR_MODE_SEL_HI && !DETECTOR_MODE_SEL_LO |-> !SUPPLY_BELOW_FLAG)
        else $error("below flag set with detector off");
    a_code_follows: assert property ($past(RST_N, 3) |-> THRESHOLD_CODE == $past(LEVEL_CODE, 2))
        else $error("threshold code not level code two cycles late");
    a_comb_irq_sets: assert property (DETECTOR_MODE_SEL_HI && !DETECTOR_MODE_SEL_LO && LOW_SUPPLY_IRQ
        |-> ##[0:1] THRESHOLD_LEVEL_SELECT && DETECTOR_ACTION_SELECT) else $error("bits not set");
    a_low_forces_rst: assert property ((DETECTOR_MODE_SEL_HI && CMP_BELOW_LOWER) [*4]
        |-> !INTERNAL_RESET_N) else $error("no reset below lower threshold");
    a_int_live_flag: assert property ((!DETECTOR_MODE_SEL_HI && DETECTOR_MODE_SEL_LO && INTERNAL_RESET_N
        && CMP_BELOW_LOWER) [*4] |-> SUPPLY_BELOW_FLAG) else $error("below flag not live");
endmodule : svrm_props
bind svrm_monitor svrm_props #(.CY_LVD_RST(8)) u_props (.*);

// *** svrm_supply_model.sv ***
// supply comparators and reset pin beside the monitor
`timescale 1ns/1ps
module svrm_supply_model (
    input  wire logic [1:0] supply,
    input  wire logic       ext_req,
    input  wire logic       det_off,
    output logic            cmp_below_upper,
    output logic            cmp_below_lower,
    output logic            ext_reset_n
);
    // analog edges land off the clock grid, so the design must resynchronise
    // continuous drive with a 7 ns delay, so the outputs stay unknown until 7 ns
    assign #7 cmp_below_upper = (supply != 2'h0);
    assign #7 cmp_below_lower = (supply == 2'h2);
    // without the detector the pin stays low until the supply is in range
    assign #7 ext_reset_n = !(ext_req || (det_off && supply != 2'h0));
    // only the on-chip oscillator runs here; no crystal needs settling
endmodule : svrm_supply_model

// *** supply_voltage_reset_monitor_tb_top.sv ***
// self-checking testbench of the supply voltage reset monitor
`timescale 1ns/1ps
module supply_voltage_reset_monitor_tb_top;
    localparam int C1L = 40, C1O = 24, C2L = 30, CD = 8;
    logic       clk_sys = 0, rst_n = 0, sel_hi = 1, sel_lo = 1, flag_read = 0, ext_req = 0;
    logic [1:0] supply = 2'h0;
    logic [3:0] level_code = 4'h3, thr;
    logic       ext_n, cmp_up, cmp_lo, irst_n, irq, below, rflag, lsel, asel;
    int         failures = 0, n_tests = 0, cyc = 0, irqs = 0, i0;
    svrm_monitor #(.CY_EXT1_LVD(C1L), .CY_EXT1_OFF(C1O), .CY_EXT2_LVD(C2L), .CY_EXT2_OFF(16),
        .CY_LVD_RST(CD)) dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .EXT_RESET_N(ext_n),
        .DETECTOR_MODE_SEL_HI(sel_hi), .DETECTOR_MODE_SEL_LO(sel_lo), .LEVEL_CODE(level_code),
        .CMP_BELOW_UPPER(cmp_up), .CMP_BELOW_LOWER(cmp_lo), .FLAG_READ(flag_read),
        .THRESHOLD_CODE(thr), .INTERNAL_RESET_N(irst_n), .LOW_SUPPLY_IRQ(irq),
        .SUPPLY_BELOW_FLAG(below), .LOW_SUPPLY_RESET_FLAG(rflag),
        .THRESHOLD_LEVEL_SELECT(lsel), .DETECTOR_ACTION_SELECT(asel));
    svrm_supply_model model (.supply(supply), .ext_req(ext_req), .det_off(!sel_hi && !sel_lo),
        .cmp_below_upper(cmp_up), .cmp_below_lower(cmp_lo), .ext_reset_n(ext_n));
    always #25 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (irq === 1'b1) irqs <= irqs + 1;
        if (cyc == 3000) begin
            failures++;
            test_done();
        end
    end
    task automatic tick(int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask : tick
    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk
    // release must land inside a window; sync latency blurs the exact edge
    task automatic rel(string what, int n);
        int c;
        c = 0;
        while (irst_n !== 1'b1 && c < n + 40) begin
            tick(1);
            c++;
        end
        chk(what, 8'h1, {7'h0, c >= n - 3 && c <= n + 6});
    endtask : rel
    task automatic start(logic h, logic l, logic [3:0] code);
        tick(1);
        sel_hi = h;
        sel_lo = l;
        level_code = code;
        rst_n = 0;
        tick(5);
        rst_n = 1;
        tick(1);
    endtask : start
    task automatic s_reset_mode;
        start(1, 1, 4'h5);
        chk("lsel", 1, lsel);
        chk("asel", 1, asel);
        rel("por release", C1L);
        chk("thr", 8'h05, {4'h0, thr});
        ext_req = 1;
        tick(6);
        ext_req = 0;
        rel("ext release", C2L);
        supply = 2;
        tick(5);
        chk("reset", 0, irst_n);
        chk("rflag", 1, rflag);
        supply = 0;
        rel("lvd release", CD);
        flag_read = 1;
        tick(1);
        flag_read = 0;
        tick(1);
        chk("rflag read", 0, rflag);
    endtask : s_reset_mode
    task automatic s_off_mode;
        supply = 2;
        start(0, 0, 4'h9);
        chk("rflag por", 0, rflag);
        tick(50);
        chk("held", 0, irst_n);
        chk("below off", 0, below);
        supply = 0;
        rel("off release", C1O);
    endtask : s_off_mode
    task automatic s_comb_mode;
        start(1, 0, 4'ha);
        chk("lsel", 0, lsel);
        chk("asel", 0, asel);
        rel("comb release", C1L);
        i0 = irqs;
        supply = 1;
        tick(5);
        chk("irq", i0 + 1, irqs);
        chk("lsel", 1, lsel);
        chk("asel", 1, asel);
        chk("no reset", 1, irst_n);
        supply = 2;
        tick(5);
        chk("reset", 0, irst_n);
        supply = 1;
        tick(60);
        chk("held", 0, irst_n);
        supply = 0;
        rel("upper release", CD);
    endtask : s_comb_mode
    task automatic s_int_mode;
        supply = 2;
        start(0, 1, 4'h1);
        tick(60);
        chk("held", 0, irst_n);
        supply = 0;
        rel("int release", C1L);
        i0 = irqs;
        supply = 2;
        tick(5);
        chk("irq fall", i0 + 1, irqs);
        chk("no reset", 1, irst_n);
        chk("below live", 1, below);
        supply = 0;
        tick(5);
        chk("irq rise", i0 + 2, irqs);
    endtask : s_int_mode
    task automatic test_done;
        $display("failures %0d n_tests %0d", failures, n_tests);
        if (failures == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    initial begin
        s_reset_mode();
        s_off_mode();
        s_comb_mode();
        s_int_mode();
        test_done();
    end
endmodule : supply_voltage_reset_monitor_tb_top
